// [rtl/nbb_host.sv]
// Host controller for a multiplexed 8-bit flash target with bad-block scan
`timescale 1ns/1ps
// How it works
// RULE1: Wait for open-drain ready before reading after busy
// RULE2: Read strobe low fetches each output byte
// RULE3: Chip select low selected, high while idle
// RULE4: Command latched on write strobe rise, CLE high
// RULE5: Address latched on write strobe rise, ALE high
// RULE6: All written bytes sampled at strobe rising edge
// RULE7: Write-protect low blocks program and erase
// RULE8: One shared eight-bit bidirectional bus
// RULE9: Column in cycle one, low five of two
// RULE10: Page number in low six of cycle three
// RULE11: Block spans cycles three to five, then die
// RULE12: Unused die bits driven low per density
// RULE13: Defective block marker is anything but FFh; code marks bad only at five or more zero bits
// RULE14: Marker sits at first byte of page
// RULE15: Never program or erase a marked block
// RULE16: Scan first and last page before writes
// RULE17: Majority zero bits at marker means bad
// RULE18: Good blocks read FFh at the marker
// RULE19: Address cycle: CE low, only ALE, read high
// RULE20: Bus released except while host writes
module nbb_host
    import nbb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic reqValid,
    input wire nbb_req_type reqKind,
    input wire logic [7:0] reqByte,
    input wire logic [12:0] reqColumn,
    input wire logic [5:0] reqPage,
    input wire logic [12:0] reqBlock,
    input wire logic [12:0] scanLastBlock,
    input wire logic [12:0] queryBlock,
    input wire logic writeProtect,
    input wire logic rbN,
    input wire logic [7:0] ioIn,
    output logic reqReady_r,
    output logic respValid_r,
    output logic [7:0] respByte_r,
    output logic respRefused_r,
    output logic scanDone_r,
    output logic queryBad_r,
    output logic ceN_r,
    output logic wpN_r,
    output logic cleOut,
    output logic aleOut,
    output logic weN,
    output logic read_strobe_n,
    output logic [7:0] shared_io_bus,
    output logic ioOeN
);
    typedef enum logic [7:0] {
        M_IDLE = 8'b00000001,
        M_CMD = 8'b00000010,
        M_ADDR = 8'b00000100,
        M_DIN = 8'b00001000,
        M_DOUT = 8'b00010000,
        M_WB = 8'b00100000,
        M_RB = 8'b01000000,
        M_EVAL = 8'b10000000
    } nbb_main_type;

    nbb_main_type state_r;
    nbb_cyc_type launchKind_r;
    logic launch_r, scan_r, scanHi_r, engDone;
    logic [7:0] launchByte_r, lastCmd_r, engByte;
    logic [12:0] col_r, blk_r;
    logic [5:0] page_r;
    logic [2:0] addrIdx_r;
    logic [3:0] cnt_r, zeroCount;
    logic arrayCmd, markBad;
    logic badMap [0:BLOCK_COUNT-1];

    nbb_cycle_engine engine (
        .clock(clock),
        .rst(rst),
        .start(launch_r),
        .kind(launchKind_r),
        .wrByte(launchByte_r),
        .ioIn(ioIn),
        .done(engDone),
        .rdByte(engByte),
        .cleOut(cleOut),
        .aleOut(aleOut),
        .weN(weN),
        .reN(read_strobe_n),
        .ioOut(shared_io_bus),
        .ioOeN(ioOeN)
    );

    always_comb begin
        zeroCount = 4'h0;
        for (int i = 0; i < 8; i++) zeroCount = zeroCount + {3'h0, ~engByte[i]};
    end
    assign markBad = (zeroCount >= ZERO_MAJORITY); // [RULE17] [RULE13] [RULE18]
    assign arrayCmd = (lastCmd_r == CMD_PROG) || (lastCmd_r == CMD_PROG_RAND)
        || (lastCmd_r == CMD_ERASE);

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= M_IDLE;
            launch_r <= 1'b0;
            launchKind_r <= CYC_CMD;
            launchByte_r <= 8'h00;
            lastCmd_r <= 8'h00;
            col_r <= 13'h0000;
            page_r <= 6'h00;
            blk_r <= 13'h0000;
            addrIdx_r <= 3'h0;
            cnt_r <= 4'h0;
            scan_r <= 1'b0;
            scanHi_r <= 1'b0;
            scanDone_r <= 1'b0;
            respValid_r <= 1'b0;
            respRefused_r <= 1'b0;
            respByte_r <= 8'h00;
        end else begin
            launch_r <= 1'b0;
            respValid_r <= 1'b0;
            respRefused_r <= 1'b0;
            case (state_r)
                M_IDLE: begin
                    if (reqValid) begin
                        case (reqKind)
                            REQ_CMD: begin
                                lastCmd_r <= reqByte;
                                launch_r <= 1'b1;
                                launchKind_r <= CYC_CMD;
                                launchByte_r <= reqByte;
                                state_r <= M_CMD;
                            end
                            REQ_ADDR: begin
                                if (arrayCmd && (!scanDone_r || badMap[reqBlock])) begin
                                    respRefused_r <= 1'b1; // [RULE15] [RULE16]
                                end else begin
                                    col_r <= reqColumn;
                                    page_r <= reqPage;
                                    blk_r <= reqBlock;
                                    // Erase takes the row cycles only
                                    addrIdx_r <= (lastCmd_r == CMD_ERASE) ? ADDR_ROW : ADDR_FIRST;
                                    launch_r <= 1'b1;
                                    launchKind_r <= CYC_ADDR;
                                    launchByte_r <= nbb_addr_byte((lastCmd_r == CMD_ERASE) ?
                                        ADDR_ROW : ADDR_FIRST, reqColumn, reqPage, reqBlock);
                                    state_r <= M_ADDR;
                                end
                            end
                            REQ_WRITE: begin
                                launch_r <= 1'b1;
                                launchKind_r <= CYC_DIN;
                                launchByte_r <= reqByte;
                                state_r <= M_DIN;
                            end
                            REQ_READ: begin
                                launch_r <= 1'b1;
                                launchKind_r <= CYC_DOUT;
                                state_r <= M_DOUT;
                            end
                            REQ_SCAN: begin
                                scan_r <= 1'b1;
                                scanDone_r <= 1'b0;
                                scanHi_r <= 1'b0;
                                blk_r <= 13'h0000;
                                page_r <= FIRST_PAGE;
                                col_r <= MARK_COL; // [RULE14]
                                launch_r <= 1'b1;
                                launchKind_r <= CYC_CMD;
                                launchByte_r <= CMD_READ1;
                                state_r <= M_CMD;
                            end
                            REQ_WAITRDY: begin
                                cnt_r <= WB_CYC;
                                state_r <= M_WB;
                            end
                            default: respRefused_r <= 1'b1;
                        endcase
                    end
                end
                M_CMD: begin
                    if (engDone) begin
                        if (scan_r && launchByte_r == CMD_READ1) begin
                            addrIdx_r <= ADDR_FIRST;
                            launch_r <= 1'b1;
                            launchKind_r <= CYC_ADDR;
                            launchByte_r <= nbb_addr_byte(ADDR_FIRST, col_r, page_r, blk_r);
                            state_r <= M_ADDR;
                        end else if (scan_r) begin
                            cnt_r <= WB_CYC;
                            state_r <= M_WB;
                        end else begin
                            respValid_r <= 1'b1;
                            state_r <= M_IDLE;
                        end
                    end
                end
                M_ADDR: begin
                    if (engDone) begin
                        if (addrIdx_r == ADDR_LAST && scan_r) begin
                            launch_r <= 1'b1;
                            launchKind_r <= CYC_CMD;
                            launchByte_r <= CMD_READ2;
                            state_r <= M_CMD;
                        end else if (addrIdx_r == ADDR_LAST) begin
                            respValid_r <= 1'b1;
                            state_r <= M_IDLE;
                        end else begin
                            addrIdx_r <= addrIdx_r + 3'h1;
                            launch_r <= 1'b1;
                            launchKind_r <= CYC_ADDR;
                            // [RULE9] [RULE10] [RULE11] [RULE12]
                            launchByte_r <= nbb_addr_byte(addrIdx_r + 3'h1, col_r, page_r, blk_r);
                        end
                    end
                end
                M_DIN: begin
                    if (engDone) begin
                        respValid_r <= 1'b1;
                        state_r <= M_IDLE;
                    end
                end
                M_DOUT: begin
                    if (engDone) begin
                        respByte_r <= engByte;
                        respValid_r <= !scan_r;
                        state_r <= scan_r ? M_EVAL : M_IDLE;
                    end
                end
                M_WB: begin
                    // Busy may take a while to show after the last strobe
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h1) state_r <= M_RB;
                end
                M_RB: begin
                    if (rbN) begin // [RULE1]
                        launch_r <= scan_r;
                        launchKind_r <= CYC_DOUT;
                        respValid_r <= !scan_r;
                        state_r <= scan_r ? M_DOUT : M_IDLE;
                    end
                end
                M_EVAL: begin
                    if (scanHi_r && blk_r == scanLastBlock) begin
                        scan_r <= 1'b0;
                        scanDone_r <= 1'b1; // [RULE16]
                        respValid_r <= 1'b1;
                        state_r <= M_IDLE;
                    end else begin
                        scanHi_r <= !scanHi_r;
                        page_r <= scanHi_r ? FIRST_PAGE : LAST_PAGE; // [RULE16]
                        blk_r <= scanHi_r ? blk_r + 13'h0001 : blk_r;
                        launch_r <= 1'b1;
                        launchKind_r <= CYC_CMD;
                        launchByte_r <= CMD_READ1;
                        state_r <= M_CMD;
                    end
                end
                default: state_r <= M_IDLE;
            endcase
        end
    end

    // Table has no reset; it is only trusted once the scan completes
    always_ff @(posedge clock) begin
        if (state_r == M_EVAL) badMap[blk_r] <= markBad || (scanHi_r && badMap[blk_r]);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ceN_r <= 1'b1;
            wpN_r <= 1'b0;
            reqReady_r <= 1'b0;
            queryBad_r <= 1'b0;
        end else begin
            ceN_r <= (state_r == M_IDLE) && !reqValid; // [RULE3] [RULE19]
            wpN_r <= !writeProtect; // [RULE7]
            reqReady_r <= (state_r == M_IDLE) && !reqValid;
            queryBad_r <= scanDone_r && badMap[queryBlock];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_CE_DURING_STROBE: assert property (!weN || !read_strobe_n |-> !ceN_r) // [RULE3]
        else $error("strobe while chip deselected");
    AST_ADDR_CYCLE_PINS: assert property (aleOut && !weN |-> !cleOut && read_strobe_n) // [RULE19]
        else $error("address cycle qualifiers wrong");
    AST_COL_HIGH_ZERO: assert property (state_r == M_ADDR && addrIdx_r == 3'h1 && !weN // [RULE9]
        |-> shared_io_bus[7:5] == 3'h0)
        else $error("second address cycle upper bits set");
    AST_FIFTH_ZERO: assert property (state_r == M_ADDR && addrIdx_r == ADDR_LAST // [RULE11]
        && !weN |-> shared_io_bus[7:3] == 5'h00)
        else $error("fifth address cycle upper bits set");
    AST_SCAN_PAGE: assert property (scan_r && state_r == M_ADDR // [RULE16]
        && addrIdx_r == ADDR_ROW && !weN
        |-> shared_io_bus[5:0] == FIRST_PAGE || shared_io_bus[5:0] == LAST_PAGE)
        else $error("scan visited a middle page");
    AST_REFUSE_QUIET: assert property (respRefused_r |-> state_r == M_IDLE && weN // [RULE15]
        ##1 weN && !aleOut)
        else $error("refused request reached the pins");
    AST_MAJORITY_MARK: assert property (state_r == M_EVAL && markBad // [RULE17]
        |=> badMap[$past(blk_r)])
        else $error("majority zero marker not recorded");
    AST_WP_FOLLOWS: assert property (writeProtect |-> ##[1:2] !wpN_r) // [RULE7]
        else $error("write protect not applied");
    AST_READY_BEFORE_READ: assert property (scan_r && $rose(state_r == M_DOUT) // [RULE1]
        |-> $past(rbN))
        else $error("scan read issued while busy");

    COV_SCAN_DONE: cover property ($rose(scanDone_r));
    COV_REFUSED: cover property (respRefused_r);
    COV_READ_BYTE: cover property (respValid_r && !scan_r && $past(state_r) == M_DOUT);
    COV_BAD_FOUND: cover property (state_r == M_EVAL && markBad);
endmodule : nbb_host

// [rtl/nbb_pkg.sv]
// Constants, types and address packing shared by the flash host controller
package nbb_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int STROBE_LOW_NS = 50;
    localparam int STROBE_HIGH_NS = 50;
    localparam int T_WB_NS = 100;
    localparam logic [3:0] LOW_CYC = 4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HIGH_CYC = 4'((STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] WB_CYC = 4'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam logic [7:0] CMD_READ1 = 8'h00;
    localparam logic [7:0] CMD_READ2 = 8'h30;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_PROG_RAND = 8'h85;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] MARK_GOOD = 8'hFF;

    localparam int BLOCK_COUNT = 8192;
    localparam logic [5:0] FIRST_PAGE = 6'h00;
    localparam logic [5:0] LAST_PAGE = 6'h3F;
    localparam logic [12:0] MARK_COL = 13'h0000;
    localparam logic [3:0] ZERO_MAJORITY = 4'h5;
    localparam logic [1:0] DIE_MASK = 2'h3;
    localparam logic [2:0] ADDR_FIRST = 3'h0;
    localparam logic [2:0] ADDR_ROW = 3'h2;
    localparam logic [2:0] ADDR_LAST = 3'h4;

    typedef enum logic [2:0] {
        REQ_CMD = 3'h0,
        REQ_ADDR = 3'h1,
        REQ_WRITE = 3'h2,
        REQ_READ = 3'h3,
        REQ_SCAN = 3'h4,
        REQ_WAITRDY = 3'h5
    } nbb_req_type;

    typedef enum logic [1:0] {
        CYC_CMD = 2'h0,
        CYC_ADDR = 2'h1,
        CYC_DIN = 2'h2,
        CYC_DOUT = 2'h3
    } nbb_cyc_type;

    // Block number carries the die bits in its top two positions
    function automatic logic [7:0] nbb_addr_byte(input logic [2:0] idx,
            input logic [12:0] col, input logic [5:0] page, input logic [12:0] blk);
        logic [1:0] die;
        die = blk[12:11] & DIE_MASK;
        case (idx)
            3'h0: nbb_addr_byte = col[7:0];
            3'h1: nbb_addr_byte = {3'h0, col[12:8]};
            3'h2: nbb_addr_byte = {blk[1:0], page};
            3'h3: nbb_addr_byte = blk[9:2];
            3'h4: nbb_addr_byte = {5'h00, die, blk[10]};
            default: nbb_addr_byte = 8'h00;
        endcase
    endfunction : nbb_addr_byte
endpackage : nbb_pkg

// [rtl/nbb_cycle_engine.sv]
// One strobed bus cycle on the shared flash pins
`timescale 1ns/1ps
module nbb_cycle_engine
    import nbb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire nbb_cyc_type kind,
    input wire logic [7:0] wrByte,
    input wire logic [7:0] ioIn,
    output logic done,
    output logic [7:0] rdByte,
    output logic cleOut,
    output logic aleOut,
    output logic weN,
    output logic reN,
    output logic [7:0] ioOut,
    output logic ioOeN
);
    typedef enum logic [2:0] {
        E_IDLE = 3'b001,
        E_LOW = 3'b010,
        E_HIGH = 3'b100
    } nbb_eng_type;

    nbb_eng_type state_r;
    nbb_cyc_type kind_r;
    logic [3:0] cnt_r;
    logic lastTick;

    assign lastTick = (cnt_r == 4'h0);

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= E_IDLE;
            cnt_r <= 4'h0;
            kind_r <= CYC_CMD;
        end else begin
            case (state_r)
                E_IDLE: begin
                    if (start) begin
                        state_r <= E_LOW;
                        cnt_r <= LOW_CYC - 4'h1;
                        kind_r <= kind;
                    end
                end
                E_LOW: begin
                    cnt_r <= lastTick ? HIGH_CYC - 4'h1 : cnt_r - 4'h1;
                    if (lastTick) state_r <= E_HIGH;
                end
                E_HIGH: begin
                    cnt_r <= cnt_r - 4'h1;
                    if (lastTick) state_r <= E_IDLE;
                end
                default: state_r <= E_IDLE;
            endcase
        end
    end

    // Data and latch qualifiers stay put across the rising strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            cleOut <= 1'b0;
            aleOut <= 1'b0;
            weN <= 1'b1;
            reN <= 1'b1;
            ioOut <= 8'h00;
            ioOeN <= 1'b1;
            rdByte <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= (state_r == E_HIGH) && lastTick;
            if (state_r == E_IDLE && start) begin
                cleOut <= (kind == CYC_CMD); // [RULE4]
                aleOut <= (kind == CYC_ADDR); // [RULE5]
                if (kind == CYC_DOUT) begin
                    reN <= 1'b0; // [RULE2]
                end else begin
                    weN <= 1'b0;
                    ioOut <= wrByte; // [RULE8]
                    ioOeN <= 1'b0;
                end
            end
            if (state_r == E_LOW && lastTick) begin
                weN <= 1'b1; // [RULE6]
                reN <= 1'b1;
                // Sampled while the read strobe is still low
                if (kind_r == CYC_DOUT) rdByte <= ioIn;
            end
            if (state_r == E_HIGH && lastTick) begin
                cleOut <= 1'b0;
                aleOut <= 1'b0;
                ioOeN <= 1'b1; // [RULE20]
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_STROBES_EXCL: assert property (!(!weN && !reN)) // [RULE2]
        else $error("write and read strobes low together");
    AST_LATCH_EXCL: assert property (!(cleOut && aleOut)) // [RULE4]
        else $error("command and address latch both high");
    AST_NO_DRIVE_ON_READ: assert property (!ioOeN |-> reN) // [RULE20]
        else $error("bus driven while read strobe low");
    AST_DATA_AT_RISE: assert property ($rose(weN) |-> $stable(ioOut) && !ioOeN) // [RULE6]
        else $error("bus changed or released at write strobe rise");
    AST_STROBE_WIDTH: assert property ($fell(weN) |-> !weN [*1] ##1 weN) // [RULE6]
        else $error("write strobe low width wrong");
endmodule : nbb_cycle_engine

// [tb/nbb_dev_model.sv]
// Behavioural flash target seen from the host pins
`timescale 1ns/1ps
module nbb_dev_model
    import nbb_pkg::*;
#(
    parameter int BUSY_NS = 600,
    parameter logic [12:0] BAD_FIRST = 13'h0001,
    parameter logic [12:0] BAD_LAST = 13'h0002,
    parameter logic [12:0] WEAK_BLK = 13'h0003
)
(
    input wire logic ceN,
    input wire logic cle,
    input wire logic ale,
    input wire logic weN,
    input wire logic reN,
    input wire logic [7:0] hostByte,
    input wire logic hostOeN,
    output logic rbN,
    output logic [7:0] busLevel
);
    logic [7:0] lastCmd = 8'hFF;
    logic [7:0] addr [5];
    logic [2:0] addrCount = 3'h0;
    logic [7:0] devByte = 8'hFF;
    logic [7:0] heldByte = 8'h00;
    logic devOe = 1'b0;
    int badPhase = 0;
    logic [12:0] col;
    logic [5:0] page;
    logic [12:0] blk;

    initial rbN = 1'b1;
    assign col = {addr[1][4:0], addr[0]};
    assign page = addr[2][5:0];
    assign blk = {addr[4][2:0], addr[3], addr[2][7:6]};
    // Floating bus shows the inverse of the last value, so no lucky match
    always_comb begin
        if (!hostOeN) busLevel = hostByte;
        else if (devOe) busLevel = devByte;
        else busLevel = ~heldByte;
    end
    always @(posedge weN) begin
        if (!ceN) begin
            heldByte <= busLevel;
            if (!reN || (cle && ale)) badPhase <= badPhase + 1;
            if (cle) begin
                lastCmd <= busLevel;
                addrCount <= 3'h0;
                if (busLevel == CMD_READ2) begin
                    rbN <= 1'b0;
                    rbN <= #(BUSY_NS) 1'b1;
                end
            end else if (ale && addrCount < 3'h5) begin
                addr[addrCount] <= busLevel;
                addrCount <= addrCount + 3'h1;
            end
        end
    end
    // Weak block has only four zero bits, so it must still count as good
    always @(negedge reN) begin
        if (!ceN && rbN) begin
            devOe <= 1'b1;
            if (col != 13'h0000) devByte <= col[7:0] ^ 8'h5A;
            else if (blk == BAD_FIRST && page == 6'h00) devByte <= 8'h00;
            else if (blk == BAD_LAST && page == 6'h3F) devByte <= 8'hE0;
            else if (blk == WEAK_BLK && page == 6'h00) devByte <= 8'hF0;
            else devByte <= 8'hFF;
        end
    end
    always @(posedge reN) begin
        heldByte <= devByte;
        devOe <= #20 1'b0;
    end
endmodule : nbb_dev_model

// [tb/nbb_host_tb_top.sv]
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module nbb_host_tb_top
    import nbb_pkg::*;
;
    logic clock, rst, reqValid, writeProtect, rbN;
    nbb_req_type reqKind;
    logic [7:0] reqByte, ioIn, respByte_r, shared_io_bus;
    logic [12:0] reqColumn, reqBlock, scanLastBlock, queryBlock;
    logic [5:0] reqPage;
    logic reqReady_r, respValid_r, respRefused_r, scanDone_r, queryBad_r, ceN_r, wpN_r;
    logic cleOut, aleOut, weN, read_strobe_n, ioOeN;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    nbb_host i_nbb_host (.clock(clock), .rst(rst), .reqValid(reqValid), .reqKind(reqKind),
        .reqByte(reqByte), .reqColumn(reqColumn), .reqPage(reqPage), .reqBlock(reqBlock),
        .scanLastBlock(scanLastBlock), .queryBlock(queryBlock), .writeProtect(writeProtect),
        .rbN(rbN), .ioIn(ioIn), .reqReady_r(reqReady_r), .respValid_r(respValid_r),
        .respByte_r(respByte_r), .respRefused_r(respRefused_r), .scanDone_r(scanDone_r),
        .queryBad_r(queryBad_r), .ceN_r(ceN_r), .wpN_r(wpN_r), .cleOut(cleOut),
        .aleOut(aleOut), .weN(weN), .read_strobe_n(read_strobe_n),
        .shared_io_bus(shared_io_bus), .ioOeN(ioOeN));
    nbb_dev_model i_nbb_dev_model (.ceN(ceN_r), .cle(cleOut), .ale(aleOut), .weN(weN),
        .reN(read_strobe_n), .hostByte(shared_io_bus), .hostOeN(ioOeN), .rbN(rbN),
        .busLevel(ioIn));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic finish_test();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    // Scan of four blocks needs well under a tenth of this
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic issue(input nbb_req_type kind, input logic [7:0] b, input logic [12:0] col,
            input logic [5:0] pg, input logic [12:0] blk, output logic refused);
        int lat;
        @(negedge clock);
        reqValid = 1'b1;
        reqKind = kind;
        reqByte = b;
        reqColumn = col;
        reqPage = pg;
        reqBlock = blk;
        @(negedge clock);
        reqValid = 1'b0;
        lat = 0;
        while (respValid_r !== 1'b1 && respRefused_r !== 1'b1 && lat < 4000) begin
            @(negedge clock);
            lat++;
        end
        if (lat >= 4000) mismatches++;
        refused = respRefused_r;
    endtask : issue
    task automatic t_reset();
        check({15'h0, ceN_r}, 16'h0001);
        check({12'h0, cleOut, aleOut, weN, read_strobe_n}, 16'h0003);
        check({15'h0, ioOeN}, 16'h0001);
        check({15'h0, wpN_r}, 16'h0000);
        writeProtect = 1'b0;
        repeat (2) @(negedge clock);
        check({15'h0, wpN_r}, 16'h0001);
        check({15'h0, reqReady_r}, 16'h0001);
    endtask : t_reset
    task automatic t_cmd_addr();
        logic rf;
        issue(REQ_CMD, CMD_READ1, 13'h0000, 6'h00, 13'h0000, rf);
        check({8'h0, i_nbb_dev_model.lastCmd}, 16'h0000);
        issue(REQ_ADDR, 8'h00, 13'h1A5C, 6'h2B, 13'h1E6D, rf);
        check({13'h0, i_nbb_dev_model.addrCount}, 16'h0005);
        check({8'h0, i_nbb_dev_model.addr[0]}, 16'h005C);
        check({8'h0, i_nbb_dev_model.addr[1]}, 16'h001A);
        check({8'h0, i_nbb_dev_model.addr[2]}, 16'h006B);
        check({8'h0, i_nbb_dev_model.addr[3]}, 16'h009B);
        check({8'h0, i_nbb_dev_model.addr[4]}, 16'h0007);
        check(16'(i_nbb_dev_model.badPhase), 16'h0000);
        issue(REQ_CMD, CMD_PROG, 13'h0000, 6'h00, 13'h0000, rf);
        issue(REQ_ADDR, 8'h00, 13'h0000, 6'h00, 13'h0003, rf);
        check({15'h0, rf}, 16'h0001);
    endtask : t_cmd_addr
    task automatic t_read();
        logic rf;
        issue(REQ_CMD, CMD_READ2, 13'h0000, 6'h00, 13'h0000, rf);
        check({15'h0, rbN}, 16'h0000);
        issue(REQ_WAITRDY, 8'h00, 13'h0000, 6'h00, 13'h0000, rf);
        check({15'h0, rbN}, 16'h0001);
        issue(REQ_READ, 8'h00, 13'h0000, 6'h00, 13'h0000, rf);
        check({8'h0, respByte_r}, 16'h0006);
        check({15'h0, ioOeN}, 16'h0001);
        issue(REQ_WRITE, 8'hA7, 13'h0000, 6'h00, 13'h0000, rf);
        check({8'h0, i_nbb_dev_model.heldByte}, 16'h00A7);
    endtask : t_read
    task automatic t_scan();
        logic rf;
        issue(REQ_SCAN, 8'h00, 13'h0000, 6'h00, 13'h0000, rf);
        check({15'h0, scanDone_r}, 16'h0001);
        for (int b = 0; b < 4; b++) begin
            @(negedge clock);
            queryBlock = 13'(b);
            @(negedge clock);
            check({15'h0, queryBad_r}, 16'(b == 1 || b == 2));
        end
    endtask : t_scan
    task automatic t_refuse();
        logic rf;
        logic [7:0] cmds [3] = '{CMD_PROG, CMD_PROG_RAND, CMD_ERASE};
        for (int i = 0; i < 3; i++) begin
            issue(REQ_CMD, cmds[i], 13'h0000, 6'h00, 13'h0000, rf);
            issue(REQ_ADDR, 8'h00, 13'h0000, 6'h00, 13'(i % 2 + 1), rf);
            check({15'h0, rf}, 16'h0001);
            check({13'h0, i_nbb_dev_model.addrCount}, 16'h0000);
        end
        issue(REQ_ADDR, 8'h00, 13'h0000, 6'h00, 13'h0003, rf);
        check({15'h0, rf}, 16'h0000);
        check({13'h0, i_nbb_dev_model.addrCount}, 16'h0003);
        check({8'h0, i_nbb_dev_model.addr[0]}, 16'h00C0);
        issue(nbb_req_type'(3'h7), 8'h00, 13'h0000, 6'h00, 13'h0000, rf);
        check({15'h0, rf}, 16'h0001);
    endtask : t_refuse
    initial begin
        rst = 1'b1;
        reqValid = 1'b0;
        reqKind = REQ_CMD;
        reqByte = 8'h00;
        reqColumn = 13'h0000;
        reqPage = 6'h00;
        reqBlock = 13'h0000;
        scanLastBlock = 13'h0003;
        queryBlock = 13'h0000;
        writeProtect = 1'b1;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        t_reset();
        t_cmd_addr();
        t_read();
        t_scan();
        t_refuse();
        finish_test();
    end
endmodule : nbb_host_tb_top
